//--- inc/ds3_alarm_consts.vh
// constants for the ds3 receive alarm monitor
// assumes inclusion by the monitor module only
`ifndef DS3_ALARM_CONSTS_VH
`define DS3_ALARM_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_ALARM_STATUS 5'h00
`define OFS_ALARM_LATCH 5'h04
`define OFS_IRQ_STATUS 5'h08
`define OFS_IRQ_MASK 5'h0C
`define OFS_CONTROL 5'h10

// ----------------------------------------
// alarm and control field positions
// ----------------------------------------
`define BIT_SIGNAL_LOSS 7
`define BIT_FRAME_LOST 6
`define BIT_ALARM_IND 5
`define BIT_IDLE_DETECT 4
`define BIT_RX_CLOCK_LOSS 3
`define BIT_TX_CLOCK_LOSS 2
`define BIT_MBIT_WINDOW 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_IRQ_MASK 8'h00
`define RST_CONTROL 1'b0

// ----------------------------------------
// frame geometry and thresholds
// ----------------------------------------
`define BLOCK_LAST 7'h54
`define ZERO_RUN_LOS 12'h800
`define ONES_TO_CLEAR 2'h2
`define FBIT_ERR_LIMIT 5'h03
`define FBIT_GOOD_NEED 5'h10
`define MBIT_GOOD_NEED 2'h2
`define MBIT_PATTERN 3'h2
`define PAYLOAD_MISS_MAX 6'h21
`define AIS_FRAMES_NEED 3'h5
`define XBIT_ONES_NEED 5'h10
`define CLOCK_LOSS_EDGES 3'h7

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define RECOVER_TIME_NS 950000

`endif

//--- hw/ds3_receive_alarm_monitor.v
// ds3 receive alarm detection with wishbone status registers
// assumes line pins come from another clock domain, bus on core_clk
`timescale 1ns/10ps
`include "ds3_alarm_consts.vh"

module ds3_receive_alarm_monitor #(
  parameter RECOVER_CYCLES = `RECOVER_TIME_NS / `CLK_PERIOD_NS
) (
  // clock, reset, enable
  input wire core_clk,
  input wire reset,
  input wire clkEn,
  // wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [4:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // line pins
  input wire line_receive_data,
  input wire line_receive_clock,
  input wire transmit_reference_clock,
  // outputs
  output reg terminalData,
  output reg transmitClockOut,
  output reg counterInhibit,
  output wire irq
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  localparam ST_SYNC = 2'h0;
  localparam ST_HUNT = 2'h1;
  localparam ST_MCHK = 2'h2;

  function [4:0] ones19;
    input [18:0] v;
    integer i;
    begin
      ones19 = 5'h00;
      for (i = 0; i < 19; i = i + 1) begin
        ones19 = ones19 + {4'h0, v[i]};
      end
    end
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg [2:0] dataSync_q;
  reg [2:0] rclkSync_q;
  reg [2:0] tclkSync_q;
  wire bitStrobe = rclkSync_q[1] & ~rclkSync_q[2];
  wire bitVal = dataSync_q[1];
  wire rclkEdge = rclkSync_q[1] ^ rclkSync_q[2];
  wire tclkRise = tclkSync_q[1] & ~tclkSync_q[2];
  wire tclkEdge = tclkSync_q[1] ^ tclkSync_q[2];

  always @(posedge core_clk) begin
    if (reset) begin
      dataSync_q <= 3'h0;
      rclkSync_q <= 3'h0;
      tclkSync_q <= 3'h0;
    end else if (clkEn) begin
      dataSync_q <= {dataSync_q[1:0], line_receive_data};
      rclkSync_q <= {rclkSync_q[1:0], line_receive_clock};
      tclkSync_q <= {tclkSync_q[1:0], transmit_reference_clock};
    end
  end

  // ----------------------------------------
  // clock loss and clock fallback
  // ----------------------------------------
  reg [2:0] rxLocCnt_q;
  reg [2:0] txLocCnt_q;
  reg rxClockLoss_q;
  reg txClockLoss_q;

  always @(posedge core_clk) begin
    if (reset) begin
      rxLocCnt_q <= 3'h0;
      txLocCnt_q <= 3'h0;
      rxClockLoss_q <= 1'b0;
      txClockLoss_q <= 1'b0;
      transmitClockOut <= 1'b0;
    end else if (clkEn) begin
      if (rclkEdge) begin
        rxLocCnt_q <= 3'h0;
        rxClockLoss_q <= 1'b0;
      end else if (tclkRise && rxLocCnt_q != `CLOCK_LOSS_EDGES) begin
        rxLocCnt_q <= rxLocCnt_q + 3'h1;
        if (rxLocCnt_q == `CLOCK_LOSS_EDGES - 3'h1) begin
          rxClockLoss_q <= 1'b1;
        end
      end
      if (tclkEdge) begin
        txLocCnt_q <= 3'h0;
        txClockLoss_q <= 1'b0;
      end else if (bitStrobe && txLocCnt_q != `CLOCK_LOSS_EDGES) begin
        txLocCnt_q <= txLocCnt_q + 3'h1;
        if (txLocCnt_q == `CLOCK_LOSS_EDGES - 3'h1) begin
          txClockLoss_q <= 1'b1;
        end
      end
      transmitClockOut <= txClockLoss_q ? rclkSync_q[1] : tclkSync_q[1];
    end
  end

  // ----------------------------------------
  // loss of signal
  // ----------------------------------------
  reg [11:0] zeroRun_q;
  reg [1:0] onesSeen_q;
  reg signalLoss_q;

  always @(posedge core_clk) begin
    if (reset) begin
      zeroRun_q <= 12'h000;
      onesSeen_q <= 2'h0;
      signalLoss_q <= 1'b0;
      terminalData <= 1'b0;
    end else if (clkEn && bitStrobe) begin
      terminalData <= bitVal;
      if (bitVal) begin
        zeroRun_q <= 12'h000;
        if (signalLoss_q) begin
          onesSeen_q <= onesSeen_q + 2'h1;
          if (onesSeen_q + 2'h1 == `ONES_TO_CLEAR) begin
            signalLoss_q <= 1'b0;
            onesSeen_q <= 2'h0;
          end
        end
      end else if (zeroRun_q != `ZERO_RUN_LOS) begin
        zeroRun_q <= zeroRun_q + 12'h001;
        if (zeroRun_q == `ZERO_RUN_LOS - 12'h001) begin
          signalLoss_q <= 1'b1;
          onesSeen_q <= 2'h0;
        end
      end
    end
  end

  // ----------------------------------------
  // framing
  // ----------------------------------------
  reg [1:0] state_q;
  reg [6:0] bitCnt_q;
  reg [2:0] blkCnt_q;
  reg [2:0] subCnt_q;
  reg [15:0] fWin_q;
  reg [3:0] mWin_q;
  reg [2:0] mShift_q;
  reg [4:0] goodF_q;
  reg [1:0] goodM_q;
  reg [16:0] recoverCnt_q;
  reg mbitWindow_q;
  wire ohBit = (bitCnt_q == 7'h00);
  wire fPos = ohBit & blkCnt_q[0];
  wire fExp = (blkCnt_q == 3'h1) | (blkCnt_q == 3'h7);
  wire fBad = fPos & (bitVal != fExp);
  wire blkEnd = (bitCnt_q == `BLOCK_LAST);
  wire subEnd = blkEnd & (blkCnt_q == 3'h7);
  wire frmEnd = subEnd & (subCnt_q == 3'h6);
  wire [2:0] mNow = {mShift_q[1:0], bitVal};
  wire [4:0] fErrCnt = ones19({3'h0, fWin_q[14:0], fBad});
  wire [3:0] mHist = {mWin_q[2:0], 1'b1};
  wire [4:0] mErrCnt = mbitWindow_q ?
    ones19({16'h0000, mHist[2:0]}) : ones19({15'h0000, mHist});
  wire frameLost = (state_q != ST_SYNC);
  reg slip;

  always @* begin
    slip = 1'b0;
    if (state_q == ST_HUNT && fBad) begin
      slip = 1'b1;
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      state_q <= ST_HUNT;
      bitCnt_q <= 7'h00;
      blkCnt_q <= 3'h0;
      subCnt_q <= 3'h0;
      fWin_q <= 16'h0000;
      mWin_q <= 4'h0;
      mShift_q <= 3'h0;
      goodF_q <= 5'h00;
      goodM_q <= 2'h0;
      recoverCnt_q <= 17'h00000;
      counterInhibit <= 1'b1;
    end else if (clkEn) begin
      counterInhibit <= frameLost;
      if (state_q == ST_SYNC) begin
        recoverCnt_q <= 17'h00000;
      end else if (recoverCnt_q == RECOVER_CYCLES[16:0]) begin
        recoverCnt_q <= 17'h00000;
        state_q <= ST_HUNT;
        goodF_q <= 5'h00;
      end else begin
        recoverCnt_q <= recoverCnt_q + 17'h00001;
      end
      if (bitStrobe) begin
        if (!slip) begin
          bitCnt_q <= blkEnd ? 7'h00 : bitCnt_q + 7'h01;
          if (blkEnd) begin
            blkCnt_q <= blkCnt_q + 3'h1;
          end
          if (subEnd) begin
            subCnt_q <= (subCnt_q == 3'h6) ? 3'h0 : subCnt_q + 3'h1;
          end
        end
        if (ohBit && blkCnt_q == 3'h0) begin
          mShift_q <= mNow;
        end
        case (state_q)
          ST_HUNT: begin
            if (fBad) begin
              goodF_q <= 5'h00;
            end else if (fPos) begin
              goodF_q <= goodF_q + 5'h01;
              if (goodF_q + 5'h01 == `FBIT_GOOD_NEED) begin
                state_q <= ST_MCHK;
                goodM_q <= 2'h0;
              end
            end
          end
          ST_MCHK: begin
            if (fBad) begin
              state_q <= ST_HUNT;
              goodF_q <= 5'h00;
            end else if (frmEnd) begin
              if (mShift_q == `MBIT_PATTERN) begin
                goodM_q <= goodM_q + 2'h1;
                if (goodM_q + 2'h1 == `MBIT_GOOD_NEED) begin
                  state_q <= ST_SYNC;
                  fWin_q <= 16'h0000;
                  mWin_q <= 4'h0;
                end
              end else begin
                goodM_q <= 2'h0;
                subCnt_q <= subCnt_q; // hunt for the M subframe
              end
            end
          end
          default: begin
            if (fPos) begin
              fWin_q <= {fWin_q[14:0], fBad};
              if (fErrCnt >= `FBIT_ERR_LIMIT) begin
                state_q <= ST_HUNT;
                goodF_q <= 5'h00;
              end
            end
            if (frmEnd) begin
              mWin_q <= {mWin_q[2:0], mShift_q != `MBIT_PATTERN};
              if (mShift_q != `MBIT_PATTERN && mErrCnt >= 5'h02) begin
                state_q <= ST_HUNT;
                goodF_q <= 5'h00;
              end
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // AIS and idle detection
  // ----------------------------------------
  reg [18:0] xHist_q;
  reg [5:0] aisMiss_q;
  reg [5:0] idlMiss_q;
  reg cNonZero_q;
  reg aisFrameOk_q;
  reg idlFrameOk_q;
  reg [2:0] aisRun_q;
  reg alarmInd_q;
  reg idleDet_q;
  wire [6:0] payIdx = bitCnt_q - 7'h01;
  wire aisExp = ~payIdx[0];
  wire idlExp = ~payIdx[1];
  wire xPos = ohBit & (blkCnt_q == 3'h0) & (subCnt_q < 3'h2);
  wire [18:0] xNext = xPos ? {xHist_q[17:0], bitVal} : xHist_q;
  wire xOk = xNext[0] & (ones19(xNext) >= `XBIT_ONES_NEED);
  wire cPos = ohBit & ~blkCnt_q[0] & (blkCnt_q != 3'h0);
  wire cNzNow = cNonZero_q | (cPos & bitVal);
  wire subAisOk = ~cNzNow & (aisMiss_q <= `PAYLOAD_MISS_MAX);
  wire subIdlOk = (idlMiss_q <= `PAYLOAD_MISS_MAX) &
    ~(cNzNow & (subCnt_q == 3'h2));
  wire frmAisOk = aisFrameOk_q & subAisOk;
  wire frmIdlOk = idlFrameOk_q & subIdlOk;
  wire [2:0] aisRunNext = frmAisOk ?
    ((aisRun_q == `AIS_FRAMES_NEED) ? aisRun_q : aisRun_q + 3'h1) : 3'h0;

  always @(posedge core_clk) begin
    if (reset) begin
      xHist_q <= 19'h00000;
      aisMiss_q <= 6'h00;
      idlMiss_q <= 6'h00;
      cNonZero_q <= 1'b0;
      aisFrameOk_q <= 1'b1;
      idlFrameOk_q <= 1'b1;
      aisRun_q <= 3'h0;
      alarmInd_q <= 1'b0;
      idleDet_q <= 1'b0;
    end else if (clkEn && bitStrobe) begin
      xHist_q <= xNext;
      if (!ohBit) begin
        if (bitVal != aisExp && aisMiss_q != 6'h3F) begin
          aisMiss_q <= aisMiss_q + 6'h01;
        end
        if (bitVal != idlExp && idlMiss_q != 6'h3F) begin
          idlMiss_q <= idlMiss_q + 6'h01;
        end
      end
      cNonZero_q <= cNzNow;
      if (xPos && !xOk) begin
        alarmInd_q <= 1'b0;
      end
      if (frameLost) begin
        alarmInd_q <= 1'b0;
        idleDet_q <= 1'b0;
      end
      if (subEnd) begin
        aisMiss_q <= 6'h00;
        idlMiss_q <= 6'h00;
        cNonZero_q <= 1'b0;
        aisFrameOk_q <= frmAisOk;
        idlFrameOk_q <= frmIdlOk;
        if (!subAisOk) begin
          alarmInd_q <= 1'b0;
        end
      end
      if (frmEnd) begin
        aisFrameOk_q <= 1'b1;
        idlFrameOk_q <= 1'b1;
        aisRun_q <= aisRunNext;
        if (!frameLost && xOk && aisRunNext == `AIS_FRAMES_NEED) begin
          alarmInd_q <= 1'b1;
        end
        idleDet_q <= !frameLost && xOk && frmIdlOk;
      end
    end
  end

  // ----------------------------------------
  // alarm vector into the bus domain
  // ----------------------------------------
  reg [7:0] alarms_q;
  reg [7:0] alarmsPrev_q;
  reg [7:0] latched_q;
  reg [7:0] irqStatus_q;
  reg [7:0] irqMask_q;
  wire [7:0] alarmsNow = {signalLoss_q, frameLost, alarmInd_q, idleDet_q,
    rxClockLoss_q, txClockLoss_q, 2'b00};
  wire [7:0] alarmRise = alarms_q & ~alarmsPrev_q;
  wire busReq = cyc_i & stb_i;
  wire wrDone = busReq & we_i & ack_o & sel_i[0];
  wire rdDone = busReq & ~we_i & ack_o;

  assign irq = |(irqStatus_q & irqMask_q);

  always @(posedge core_clk) begin
    if (reset) begin
      alarms_q <= 8'h00;
      alarmsPrev_q <= 8'h00;
      latched_q <= 8'h00;
      irqStatus_q <= 8'h00;
      irqMask_q <= `RST_IRQ_MASK;
      mbitWindow_q <= `RST_CONTROL;
    end else if (clkEn) begin
      alarms_q <= alarmsNow;
      alarmsPrev_q <= alarms_q;
      if (rdDone && adr_i == `OFS_ALARM_LATCH) begin
        latched_q <= alarms_q;
      end else begin
        latched_q <= latched_q | alarms_q;
      end
      if (wrDone && adr_i == `OFS_IRQ_STATUS) begin
        irqStatus_q <= (irqStatus_q & ~dat_i[7:0]) | alarmRise;
      end else begin
        irqStatus_q <= irqStatus_q | alarmRise;
      end
      if (wrDone && adr_i == `OFS_IRQ_MASK) begin
        irqMask_q <= dat_i[7:0];
      end
      if (wrDone && adr_i == `OFS_CONTROL) begin
        mbitWindow_q <= dat_i[`BIT_MBIT_WINDOW];
      end
    end
  end

  // ----------------------------------------
  // wishbone answer
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (reset) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else if (clkEn) begin
      ack_o <= busReq & ~ack_o;
      dat_o <= 32'h00000000;
      if (busReq && !ack_o && !we_i) begin
        if (adr_i == `OFS_ALARM_STATUS) begin
          dat_o <= {24'h000000, alarms_q};
        end else if (adr_i == `OFS_ALARM_LATCH) begin
          dat_o <= {24'h000000, latched_q | alarms_q};
        end else if (adr_i == `OFS_IRQ_STATUS) begin
          dat_o <= {24'h000000, irqStatus_q};
        end else if (adr_i == `OFS_IRQ_MASK) begin
          dat_o <= {24'h000000, irqMask_q};
        end else if (adr_i == `OFS_CONTROL) begin
          dat_o <= {31'h00000000, mbitWindow_q};
        end
      end
    end
  end

endmodule

//--- sim/ds3_line_model.sv
// line side model: receive clock and data
// assumes 80 ns line clock, data moved on falling edge
`timescale 1ns/10ps
module ds3_line_model (
  // control
  input wire run,
  input wire [1:0] pattern,
  // line pins
  output reg lineClock,
  output reg lineData
);
  // -------------------------------
  // clock halts low, data 0/1/toggle
  // -------------------------------
  initial begin
    lineClock = 1'b0;
    lineData = 1'b0;
  end
  always #40 begin
    if (run || lineClock)
      lineClock = ~lineClock;
    if (!lineClock)
      lineData = pattern[1] ? ~lineData : pattern[0];
  end
endmodule

//--- sim/ds3_alarm_chk.sv
// checker: alarm monitor port relations
// assumes bind onto the monitor top, core_clk only
`timescale 1ns/10ps
module ds3_alarm_chk (
  // clock and reset
  input wire core_clk,
  input wire reset,
  input wire clkEn,
  // bus
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [4:0] adr_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  // line and outputs
  input wire line_receive_data,
  input wire line_receive_clock,
  input wire transmit_reference_clock,
  input wire transmitClockOut,
  input wire counterInhibit,
  input wire irq
);
  // -------------------------------
  // helper counters
  // -------------------------------
  reg [7:0] upCnt_q;
  reg [7:0] lineAge_q;
  reg [7:0] refAge_q;
  reg [11:0] zeroRun_q;
  reg [2:0] onesCnt_q;
  wire statRead;
  assign statRead = ack_o && !we_i && adr_i == 5'h00;
  always @(posedge core_clk) begin
    if (reset) begin
      upCnt_q <= 8'h00;
      lineAge_q <= 8'h00;
      refAge_q <= 8'h00;
      zeroRun_q <= 12'h000;
      onesCnt_q <= 3'h0;
    end else begin
      upCnt_q <= upCnt_q + {7'h00, upCnt_q != 8'hFF};
      lineAge_q <= $changed(line_receive_clock) ? 8'h00 :
        lineAge_q + {7'h00, lineAge_q != 8'hFF};
      refAge_q <= $changed(transmit_reference_clock) ? 8'h00 :
        refAge_q + {7'h00, refAge_q != 8'hFF};
      if ($rose(line_receive_clock)) begin
        zeroRun_q <= line_receive_data ? 12'h000 :
          zeroRun_q + {11'h000, zeroRun_q != 12'hFFF};
        if (zeroRun_q >= 12'h7F0)
          onesCnt_q <= 3'h0;
        else if (line_receive_data && onesCnt_q != 3'h7)
          onesCnt_q <= onesCnt_q + 3'h1;
      end
    end
  end
  // -------------------------------
  // assertions
  // -------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  ack_answer_a:
    assert property (cyc_i && stb_i && !ack_o && clkEn |=> ack_o)
    else $error("request not acknowledged next cycle");
  ack_pulse_a:
    assert property (ack_o && clkEn |=> !ack_o)
    else $error("ack held longer than one cycle");
  irq_clear_a:
    assert property ($fell(irq) |-> $past(ack_o) && $past(we_i))
    else $error("irq fell without a write");
  inhibit_hunt_a:
    assert property (upCnt_q < 8'hC8 |-> counterInhibit)
    else $error("counters not inhibited while hunting");
  los_set_a:
    assert property (statRead && zeroRun_q > 12'h808 |-> dat_o[7])
    else $error("signal loss missing after zero run");
  los_clear_a:
    assert property (statRead && onesCnt_q >= 3'h4 |-> !dat_o[7])
    else $error("signal loss kept after ones");
  rxloss_set_a:
    assert property (statRead && lineAge_q > 8'h64 && refAge_q < 8'h05
      |-> dat_o[3])
    else $error("receive clock loss missing");
  txloss_set_a:
    assert property (statRead && refAge_q > 8'h64 && lineAge_q < 8'h05
      |-> dat_o[2])
    else $error("transmit clock loss missing");
  fallback_a:
    assert property (refAge_q > 8'h64 && $rose(line_receive_clock)
      |-> ##[1:8] transmitClockOut ##[1:8] !transmitClockOut)
    else $error("line clock not substituted");
  cover property (statRead && dat_o[7]);
  cover property (statRead && dat_o[2]);
  cover property ($rose(irq));
endmodule
bind ds3_receive_alarm_monitor ds3_alarm_chk u_chk (.core_clk, .reset,
  .clkEn, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o,
  .line_receive_data, .line_receive_clock, .transmit_reference_clock,
  .transmitClockOut, .counterInhibit, .irq);

//--- sim/ds3_receive_alarm_monitor_tb.sv
// bench: alarm monitor over wishbone with line model
// assumes line model and checker compiled first
`timescale 1ns/10ps
module ds3_receive_alarm_monitor_tb;
  reg core_clk;
  reg reset;
  reg cyc_i;
  reg stb_i;
  reg we_i;
  reg [4:0] adr_i;
  reg [3:0] sel_i;
  reg [31:0] dat_i;
  wire [31:0] dat_o;
  wire ack_o;
  wire lineClk;
  wire lineDat;
  wire termData;
  wire txClk;
  wire inhibit;
  wire irq;
  reg refClk;
  reg refRun;
  reg lineRun;
  reg [1:0] pat;
  reg prevTx;
  reg [31:0] q;
  integer err_total;
  integer check_count;
  integer cycles;
  integer n;
  ds3_receive_alarm_monitor #(.RECOVER_CYCLES(20000))
    u_ds3_receive_alarm_monitor (.core_clk(core_clk), .reset(reset),
    .clkEn(1'b1), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .line_receive_data(lineDat),
    .line_receive_clock(lineClk), .transmit_reference_clock(refClk),
    .terminalData(termData), .transmitClockOut(txClk),
    .counterInhibit(inhibit), .irq(irq));
  ds3_line_model u_ds3_line_model (.run(lineRun), .pattern(pat),
    .lineClock(lineClk), .lineData(lineDat));
  // -------------------------------
  // clocks, watchdog, tasks
  // -------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always #30 if (refRun || refClk) refClk = ~refClk;
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 25000) begin
      err_total = err_total + 1;
      test_done;
    end
  end
  task test_done;
    begin
      if (err_total == 0 && check_count > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("[ERR] %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task bus(input [4:0] a, input w, input [3:0] s, input [7:0] d);
    begin
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= s;
      dat_i <= {24'h000000, d};
      do @(posedge core_clk); while (ack_o !== 1'b1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  task rd(input [4:0] a, input [7:0] e);
    begin
      bus(a, 1'b0, 4'hF, 8'h00);
      chk($sformatf("reg %h", a), {24'h000000, e}, q);
    end
  endtask
  task wr(input [4:0] a, input [7:0] d);
    bus(a, 1'b1, 4'hF, d);
  endtask
  task waitc(input integer k);
    repeat (k) @(posedge core_clk);
  endtask
  // -------------------------------
  // main sequence
  // -------------------------------
  initial begin
    reset = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 5'h00;
    sel_i = 4'h0;
    dat_i = 32'h00000000;
    refClk = 1'b0;
    refRun = 1'b1;
    lineRun = 1'b1;
    pat = 2'h1;
    err_total = 0;
    check_count = 0;
    cycles = 0;
    waitc(16);
    reset <= 1'b0;
    waitc(200);
    rd(5'h00, 8'h40);
    chk("inhibit", 1, inhibit);
    chk("terminal", 1, termData);
    rd(5'h0C, 8'h00);
    wr(5'h10, 8'h01);
    rd(5'h10, 8'h01);
    bus(5'h10, 1'b1, 4'h0, 8'h00);
    rd(5'h10, 8'h01);
    wr(5'h10, 8'h00);
    rd(5'h10, 8'h00);
    wr(5'h1C, 8'hFF);
    rd(5'h1C, 8'h00);
    wr(5'h0C, 8'h80);
    wr(5'h08, 8'hFF);
    chk("irq", 0, irq);
    pat <= 2'h0;
    waitc(16300);
    rd(5'h00, 8'h40);
    waitc(300);
    rd(5'h00, 8'hC0);
    chk("terminal", 0, termData);
    chk("irq", 1, irq);
    rd(5'h04, 8'hC0);
    rd(5'h04, 8'hC0);
    rd(5'h08, 8'h80);
    wr(5'h08, 8'h80);
    chk("irq", 0, irq);
    @(posedge lineClk);
    pat <= 2'h1;
    @(posedge lineClk);
    pat <= 2'h0;
    waitc(100);
    rd(5'h00, 8'hC0);
    pat <= 2'h2;
    waitc(100);
    rd(5'h00, 8'h40);
    lineRun <= 1'b0;
    waitc(150);
    rd(5'h00, 8'h48);
    chk("irq", 0, irq);
    lineRun <= 1'b1;
    waitc(20);
    rd(5'h00, 8'h40);
    refRun <= 1'b0;
    waitc(150);
    rd(5'h00, 8'h44);
    n = 0;
    prevTx = txClk;
    repeat (80) begin
      @(posedge core_clk);
      n = n + (txClk !== prevTx);
      prevTx = txClk;
    end
    chk("txclk toggles", 1, n >= 18);
    refRun <= 1'b1;
    waitc(20);
    rd(5'h00, 8'h40);
    wr(5'h0C, 8'hFF);
    chk("irq", 1, irq);
    reset <= 1'b1;
    waitc(16);
    reset <= 1'b0;
    waitc(10);
    chk("irq", 0, irq);
    rd(5'h0C, 8'h00);
    rd(5'h00, 8'h40);
    test_done;
  end
endmodule
